/* File: mie_core.sv */
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
module mie_core #(
  parameter int STACK_DEPTH = 8,
  parameter int SP_W = 3
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // program memory
  output logic [12:0] pc_o,
  input wire logic [13:0] instr_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core status
  output logic running_o
);

  typedef struct packed {
    mie_pkg::mie_state_t st;
    logic [1:0] phase;
    logic run;
    logic [7:0] work;
    logic carry;
    logic digit_carry_flag;
    logic zero;
    logic timeout_status_bit;
    logic powerdown_status_bit;
    logic global_irq_enable;
    logic [4:0] pc_high_latch;
    logic [12:0] pc;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][12:0] stack;
    logic [7:0] watchdog_counter;
    logic [7:0] wd_prescale;
    logic ack;
    logic [31:0] rdata;
  } mie_regs_t;

  mie_regs_t q;
  mie_regs_t d;
  logic [7:0] file_mem [mie_pkg::FILE_WORDS];
  logic mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;

  mie_pkg::mie_op_t op;
  logic [6:0] fa;
  logic dest_file;
  logic [2:0] bsel;
  logic [7:0] k8;
  logic [10:0] k11;
  logic [7:0] fv;
  logic exec;
  logic fire;
  logic bus_req;
  logic file_hit;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic wr_res;
  logic dst_file;
  logic upd_z;
  logic skip;
  logic two_cycle;

  // operand fields of the single instruction word
  assign op = mie_pkg::decode_op(instr_i);
  assign fa = instr_i[6:0];
  assign dest_file = instr_i[7];
  assign bsel = instr_i[9:7];
  assign k8 = instr_i[7:0];
  assign k11 = instr_i[10:0];
  assign fv = file_mem[fa];
  assign exec = (q.st == mie_pkg::S_EXEC) && (q.phase == mie_pkg::LAST_PHASE);
  assign fire = exec && ce_i;
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign file_hit = (wb_adr_i[11:9] == mie_pkg::ADR_FILE_BASE[11:9]);

  assign pc_o = q.pc;
  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign running_o = (q.st != mie_pkg::S_STOP);

  always_comb begin
    d = q;
    mem_we = 1'b0;
    mem_addr = fa;
    mem_wdata = 8'h00;
    sum = 9'h000;
    nib = 5'h00;
    res = 8'h00;
    wr_res = 1'b0;
    dst_file = dest_file;
    upd_z = 1'b0;
    skip = 1'b0;
    two_cycle = 1'b0;

    // bus slave: one wait state, ack held one cycle
    d.ack = bus_req && !q.ack;
    if (bus_req && !q.ack) begin
      d.rdata = 32'h0000_0000;
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          mie_pkg::ADR_CTRL: d.run = wb_dat_i[mie_pkg::CTRL_RUN_BIT];
          mie_pkg::ADR_WORK: d.work = wb_dat_i[7:0];
          mie_pkg::ADR_STATUS: begin
            d.carry = wb_dat_i[mie_pkg::STAT_CARRY_BIT];
            d.digit_carry_flag = wb_dat_i[mie_pkg::STAT_DIGIT_BIT];
            d.zero = wb_dat_i[mie_pkg::STAT_ZERO_BIT];
          end
          mie_pkg::ADR_LATCH: d.pc_high_latch = wb_dat_i[4:0];
          mie_pkg::ADR_IRQ: d.global_irq_enable = wb_dat_i[mie_pkg::IRQ_ENABLE_BIT];
          default: begin
            if (file_hit) begin
              mem_we = 1'b1;
              mem_addr = wb_adr_i[8:2];
              mem_wdata = wb_dat_i[7:0];
            end
          end
        endcase
      end else if (!wb_we_i) begin
        case (wb_adr_i)
          mie_pkg::ADR_CTRL: d.rdata = 32'(q.run);
          mie_pkg::ADR_WORK: d.rdata = 32'(q.work);
          mie_pkg::ADR_STATUS: d.rdata = 32'({q.timeout_status_bit, q.powerdown_status_bit,
                                              q.zero, q.digit_carry_flag, q.carry});
          mie_pkg::ADR_LATCH: d.rdata = 32'(q.pc_high_latch);
          mie_pkg::ADR_PC: d.rdata = 32'(q.pc);
          mie_pkg::ADR_IRQ: d.rdata = 32'(q.global_irq_enable);
          mie_pkg::ADR_WATCHDOG: d.rdata = 32'({q.wd_prescale, q.watchdog_counter});
          default: d.rdata = file_hit ? 32'(file_mem[wb_adr_i[8:2]]) : 32'h0000_0000;
        endcase
      end
    end

    // four-phase instruction cycle
    if (q.st != mie_pkg::S_STOP) begin
      d.phase = q.phase + 2'h1;
      if (q.phase == mie_pkg::LAST_PHASE) begin
        {d.watchdog_counter, d.wd_prescale} = {q.watchdog_counter, q.wd_prescale} + 16'h0001;
      end
    end

    case (q.st)
      mie_pkg::S_STOP: begin
        d.phase = 2'h0;
        if (q.run) begin
          d.st = mie_pkg::S_EXEC;
        end
      end
      mie_pkg::S_EXEC: begin
        if (exec) begin
          d.pc = q.pc + 13'h0001;
          case (op)
            mie_pkg::OP_ADD_LITERAL, mie_pkg::OP_ADD_TO_FILE: begin
              if (op == mie_pkg::OP_ADD_LITERAL) begin
                sum = {1'b0, q.work} + {1'b0, k8};
                nib = {1'b0, q.work[3:0]} + {1'b0, k8[3:0]};
                dst_file = 1'b0;
              end else begin
                sum = {1'b0, q.work} + {1'b0, fv};
                nib = {1'b0, q.work[3:0]} + {1'b0, fv[3:0]};
              end
              res = sum[7:0];
              wr_res = 1'b1;
              upd_z = 1'b1;
              d.carry = sum[8];
              d.digit_carry_flag = nib[4];
            end
            mie_pkg::OP_AND_LITERAL: begin
              res = q.work & k8;
              {wr_res, dst_file, upd_z} = 3'b101;
            end
            mie_pkg::OP_AND_WITH_FILE: begin
              res = q.work & fv;
              {wr_res, upd_z} = 2'b11;
            end
            mie_pkg::OP_OR_LITERAL: begin
              res = q.work | k8;
              {wr_res, dst_file, upd_z} = 3'b101;
            end
            mie_pkg::OP_OR_WITH_FILE: begin
              res = q.work | fv;
              {wr_res, upd_z} = 2'b11;
            end
            mie_pkg::OP_LOAD_LITERAL: begin
              res = k8;
              {wr_res, dst_file} = 2'b10;
            end
            mie_pkg::OP_BIT_CLEAR_FILE, mie_pkg::OP_BIT_SET_FILE: begin
              res = (op == mie_pkg::OP_BIT_SET_FILE) ? (fv | (8'h01 << bsel)) : (fv & ~(8'h01 << bsel));
              {wr_res, dst_file} = 2'b11;
            end
            mie_pkg::OP_TEST_SKIP_IF_SET: skip = fv[bsel];
            mie_pkg::OP_TEST_SKIP_IF_CLEAR: skip = !fv[bsel];
            mie_pkg::OP_CALL: begin
              d.stack[q.sp] = q.pc + 13'h0001;
              d.sp = q.sp + 1'b1;
              d.pc = {q.pc_high_latch[4:3], k11};
              two_cycle = 1'b1;
            end
            mie_pkg::OP_UNCONDITIONAL_BRANCH: begin
              d.pc = {q.pc_high_latch[4:3], k11};
              two_cycle = 1'b1;
            end
            mie_pkg::OP_INTERRUPT_RETURN: begin
              d.sp = q.sp - 1'b1;
              d.pc = q.stack[q.sp - 1'b1];
              d.global_irq_enable = 1'b1;
              two_cycle = 1'b1;
            end
            mie_pkg::OP_CLEAR_FILE: begin
              res = 8'h00;
              {wr_res, dst_file, upd_z} = 3'b111;
            end
            mie_pkg::OP_CLEAR_WORKING: begin
              res = 8'h00;
              {wr_res, dst_file, upd_z} = 3'b101;
            end
            mie_pkg::OP_WATCHDOG_CLEAR: begin
              d.watchdog_counter = 8'h00;
              d.wd_prescale = 8'h00;
              d.timeout_status_bit = 1'b1;
              d.powerdown_status_bit = 1'b1;
            end
            mie_pkg::OP_COMPLEMENT_FILE: begin
              res = ~fv;
              {wr_res, upd_z} = 2'b11;
            end
            mie_pkg::OP_DECREMENT_FILE, mie_pkg::OP_INCREMENT_FILE: begin
              res = (op == mie_pkg::OP_INCREMENT_FILE) ? fv + 8'h01 : fv - 8'h01;
              {wr_res, upd_z} = 2'b11;
            end
            mie_pkg::OP_DECREMENT_SKIP_ZERO: begin
              res = fv - 8'h01;
              wr_res = 1'b1;
              skip = (res == 8'h00);
            end
            mie_pkg::OP_INCREMENT_SKIP_ZERO: begin
              res = fv + 8'h01;
              wr_res = 1'b1;
              skip = (res == 8'h00);
            end
            mie_pkg::OP_MOVE_FILE: begin
              res = fv;
              {wr_res, upd_z} = 2'b11;
            end
            mie_pkg::OP_STORE_WORKING: begin
              res = q.work;
              {wr_res, dst_file} = 2'b11;
            end
            mie_pkg::OP_ROTATE_LEFT_CARRY: begin
              res = {fv[6:0], q.carry};
              wr_res = 1'b1;
              d.carry = fv[7];
            end
            // unsupported opcodes run as a plain one-cycle no-operation
            default: wr_res = 1'b0;
          endcase
          // core write wins over a bus write to the same array in the same cycle
          if (wr_res) begin
            if (dst_file) begin
              mem_we = 1'b1;
              mem_addr = fa;
              mem_wdata = res;
            end else begin
              d.work = res;
            end
          end
          if (upd_z) begin
            d.zero = (res == 8'h00);
          end
          d.pc = skip ? q.pc + 13'h0002 : d.pc;
          two_cycle = two_cycle | skip;
          if (two_cycle) begin
            d.st = mie_pkg::S_FLUSH;
          end else if (!q.run) begin
            d.st = mie_pkg::S_STOP;
          end
        end
      end
      mie_pkg::S_FLUSH: begin
        // the fetched word is discarded: this cycle executes as a no-operation
        if (q.phase == mie_pkg::LAST_PHASE) begin
          d.st = q.run ? mie_pkg::S_EXEC : mie_pkg::S_STOP;
        end
      end
      default: d.st = mie_pkg::S_STOP;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= mie_pkg::S_STOP;
      q.run <= mie_pkg::RST_RUN;
      q.pc <= mie_pkg::RST_PC;
      q.timeout_status_bit <= mie_pkg::RST_TIMEOUT;
      q.powerdown_status_bit <= mie_pkg::RST_POWERDOWN;
    end else if (ce_i) begin
      q <= d;
      if (mem_we) begin
        file_mem[mem_addr] <= mem_wdata;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_op(mie_pkg::mie_op_t o);
    fire && op == o;
  endsequence

  sequence s_flush_next;
    q.st == mie_pkg::S_FLUSH;
  endsequence

  a_add_literal: assert property (s_op(mie_pkg::OP_ADD_LITERAL) |=>
    {q.carry, q.work} == $past({1'b0, q.work} + {1'b0, k8}) && q.zero == (q.work == 8'h00))
    else $error("literal add result or flags wrong");
  a_add_file_w: assert property (s_op(mie_pkg::OP_ADD_TO_FILE) ##0 !dest_file |=>
    {q.carry, q.work} == $past({1'b0, q.work} + {1'b0, fv}))
    else $error("file add into working wrong");
  a_dest_file: assert property (s_op(mie_pkg::OP_MOVE_FILE) ##0 dest_file |=>
    $stable(q.work) && file_mem[$past(fa)] == $past(fv) && q.zero == ($past(fv) == 8'h00))
    else $error("destination one did not keep working register");
  a_and_flags: assert property (s_op(mie_pkg::OP_AND_LITERAL) |=>
    $stable(q.carry) && $stable(q.digit_carry_flag) && q.work == $past(q.work & k8))
    else $error("literal and touched carry or wrong result");
  a_bit_clear: assert property (s_op(mie_pkg::OP_BIT_CLEAR_FILE) |=>
    file_mem[$past(fa)][$past(bsel)] == 1'b0 && $stable(q.zero) && $stable(q.carry))
    else $error("bit clear failed or changed flags");
  a_skip_set: assert property (s_op(mie_pkg::OP_TEST_SKIP_IF_SET) |=>
    (q.st == mie_pkg::S_FLUSH) == $past(fv[bsel]))
    else $error("skip if set took wrong path");
  a_skip_clear: assert property (s_op(mie_pkg::OP_TEST_SKIP_IF_CLEAR) |=>
    (q.st == mie_pkg::S_FLUSH) == !$past(fv[bsel]))
    else $error("skip if clear took wrong path");
  a_call_push: assert property (s_op(mie_pkg::OP_CALL) |=> s_flush_next ##0
    q.pc == {$past(q.pc_high_latch[4:3]), $past(k11)} && q.stack[$past(q.sp)] == $past(q.pc) + 13'h0001)
    else $error("call target or return address wrong");
  a_branch_stack: assert property (s_op(mie_pkg::OP_UNCONDITIONAL_BRANCH) |=> s_flush_next ##0
    $stable(q.sp) && q.pc == {$past(q.pc_high_latch[4:3]), $past(k11)})
    else $error("branch target wrong or stack moved");
  a_clear_work: assert property (s_op(mie_pkg::OP_CLEAR_WORKING) |=> q.work == 8'h00 && q.zero)
    else $error("working clear failed");
  a_watchdog_clear: assert property (s_op(mie_pkg::OP_WATCHDOG_CLEAR) |=>
    q.watchdog_counter == 8'h00 && q.wd_prescale == 8'h00 && q.timeout_status_bit && q.powerdown_status_bit)
    else $error("watchdog clear incomplete");
  a_dec_skip: assert property (s_op(mie_pkg::OP_DECREMENT_SKIP_ZERO) |=>
    $stable(q.zero) && $stable(q.carry) && (q.st == mie_pkg::S_FLUSH) == ($past(fv) == 8'h01))
    else $error("decrement skip wrong");
  a_four_phase: assert property (fire |=> !exec [*3])
    else $error("instruction executed inside four phase cycle");
  a_irq_return: assert property (s_op(mie_pkg::OP_INTERRUPT_RETURN) |=> s_flush_next ##0
    q.global_irq_enable && q.pc == $past(q.stack[q.sp - 1'b1]) && q.sp == $past(q.sp) - 1'b1)
    else $error("interrupt return wrong");
  a_nop_quiet: assert property (s_op(mie_pkg::OP_NO_OPERATION) ##0 !(bus_req && !q.ack) |=>
    $stable(q.work) && $stable(q.zero) && $stable(q.carry) && q.st != mie_pkg::S_FLUSH)
    else $error("no-operation changed state");

endmodule : mie_core

/* File: mie_pkg.sv */
package mie_pkg;

  // word and field widths
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FILE_ADR_W = 7;
  localparam int FILE_WORDS = 128;
  localparam int LATCH_W = 5;
  localparam int BUS_ADR_W = 12;

  // instruction cycle: four clock phases, execution in the last
  localparam int PHASES = 4;
  localparam logic [1:0] LAST_PHASE = 2'(PHASES - 1);

  // register byte offsets
  localparam logic [11:0] ADR_CTRL = 12'h000;
  localparam logic [11:0] ADR_WORK = 12'h004;
  localparam logic [11:0] ADR_STATUS = 12'h008;
  localparam logic [11:0] ADR_LATCH = 12'h00C;
  localparam logic [11:0] ADR_PC = 12'h010;
  localparam logic [11:0] ADR_IRQ = 12'h014;
  localparam logic [11:0] ADR_WATCHDOG = 12'h018;
  localparam logic [11:0] ADR_FILE_BASE = 12'h200;

  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int IRQ_ENABLE_BIT = 0;
  localparam int STAT_CARRY_BIT = 0;
  localparam int STAT_DIGIT_BIT = 1;
  localparam int STAT_ZERO_BIT = 2;
  localparam int STAT_POWERDOWN_BIT = 3;
  localparam int STAT_TIMEOUT_BIT = 4;

  // reset values
  localparam logic RST_RUN = 1'h0;
  localparam logic RST_TIMEOUT = 1'h1;
  localparam logic RST_POWERDOWN = 1'h1;
  localparam logic [12:0] RST_PC = 13'h0000;

  typedef enum logic [2:0] {
    S_STOP = 3'b001,
    S_EXEC = 3'b010,
    S_FLUSH = 3'b100
  } mie_state_t;

  typedef enum logic [4:0] {
    OP_NO_OPERATION, OP_ADD_LITERAL, OP_ADD_TO_FILE, OP_AND_LITERAL, OP_AND_WITH_FILE,
    OP_BIT_CLEAR_FILE, OP_BIT_SET_FILE, OP_TEST_SKIP_IF_SET, OP_TEST_SKIP_IF_CLEAR,
    OP_CALL, OP_UNCONDITIONAL_BRANCH, OP_CLEAR_FILE, OP_CLEAR_WORKING, OP_WATCHDOG_CLEAR,
    OP_COMPLEMENT_FILE, OP_DECREMENT_FILE, OP_INCREMENT_FILE, OP_DECREMENT_SKIP_ZERO,
    OP_INCREMENT_SKIP_ZERO, OP_OR_LITERAL, OP_OR_WITH_FILE, OP_LOAD_LITERAL,
    OP_STORE_WORKING, OP_MOVE_FILE, OP_INTERRUPT_RETURN, OP_ROTATE_LEFT_CARRY,
    OP_UNSUPPORTED
  } mie_op_t;

  function automatic mie_op_t decode_op(input logic [13:0] i);
    mie_op_t o;
    o = OP_UNSUPPORTED;
    casez (i)
      14'b00_0000_0110_0100: o = OP_WATCHDOG_CLEAR;
      14'b00_0000_0000_1001: o = OP_INTERRUPT_RETURN;
      14'b00_0000_0??0_0000: o = OP_NO_OPERATION;
      14'b00_0000_1???_????: o = OP_STORE_WORKING;
      14'b00_0001_1???_????: o = OP_CLEAR_FILE;
      14'b00_0001_0???_????: o = OP_CLEAR_WORKING;
      14'b00_0111_????_????: o = OP_ADD_TO_FILE;
      14'b00_0101_????_????: o = OP_AND_WITH_FILE;
      14'b00_1001_????_????: o = OP_COMPLEMENT_FILE;
      14'b00_0011_????_????: o = OP_DECREMENT_FILE;
      14'b00_1011_????_????: o = OP_DECREMENT_SKIP_ZERO;
      14'b00_1010_????_????: o = OP_INCREMENT_FILE;
      14'b00_1111_????_????: o = OP_INCREMENT_SKIP_ZERO;
      14'b00_0100_????_????: o = OP_OR_WITH_FILE;
      14'b00_1000_????_????: o = OP_MOVE_FILE;
      14'b00_1101_????_????: o = OP_ROTATE_LEFT_CARRY;
      14'b01_00??_????_????: o = OP_BIT_CLEAR_FILE;
      14'b01_01??_????_????: o = OP_BIT_SET_FILE;
      14'b01_10??_????_????: o = OP_TEST_SKIP_IF_CLEAR;
      14'b01_11??_????_????: o = OP_TEST_SKIP_IF_SET;
      14'b10_0???_????_????: o = OP_CALL;
      14'b10_1???_????_????: o = OP_UNCONDITIONAL_BRANCH;
      14'b11_111?_????_????: o = OP_ADD_LITERAL;
      14'b11_1001_????_????: o = OP_AND_LITERAL;
      14'b11_1000_????_????: o = OP_OR_LITERAL;
      14'b11_00??_????_????: o = OP_LOAD_LITERAL;
      default: o = OP_UNSUPPORTED;
    endcase
    return o;
  endfunction : decode_op

endpackage : mie_pkg

/* File: mie_pmem.sv */
module mie_pmem (
  // fetch port
  input wire logic [12:0] pc_i,
  output logic [13:0] instr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // full 13-bit space so both page bits of a jump target are reachable
  logic [13:0] mem [8192];
  assign instr_o = mem[pc_i]; // one whole word per fetch

  // unwritten words read as no-operation, never as unknown
  task automatic clear_all();
    foreach (mem[i]) mem[i] = 14'h0000;
  endtask : clear_all
endmodule : mie_pmem

/* File: mie_tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [3:0] wb_sel = 4'h1;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic running;
  logic [12:0] pc;
  logic [13:0] instr;
  logic [31:0] rd;
  int fail_count = 0;
  int checks_done = 0;

  always #2.5 clk_i = ~clk_i;

  mie_core dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .pc_o(pc), .instr_i(instr), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .running_o(running));
  mie_pmem pm (.pc_i(pc), .instr_o(instr));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic give_up();
    fail_count++;
    $display("MISMATCH at %0t: wait timed out", $time);
    report_and_stop();
  endtask : give_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ack is read before the edge's own updates land, so it is the sampled value
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 64);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 64) give_up();
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc

  function automatic logic [11:0] fa(input int n);
    return mie_pkg::ADR_FILE_BASE + 12'(4 * n);
  endfunction : fa

  function automatic logic [13:0] fd(input logic [13:0] base, input logic d, input logic [6:0] f);
    return base | {6'h00, d, f};
  endfunction : fd

  function automatic logic [13:0] bt(input logic [13:0] base, input logic [2:0] b, input logic [6:0] f);
    return base | {4'h0, b, f};
  endfunction : bt

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    pm.clear_all();
  endtask : do_reset

  // start, wait for the closing self-branch, then stop at a boundary
  task automatic run_to(input logic [12:0] stop_pc);
    int n;
    n = 0;
    wr(mie_pkg::ADR_CTRL, 32'h1);
    while (pc !== stop_pc && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) give_up();
    repeat (16) @(posedge clk_i);
    wr(mie_pkg::ADR_CTRL, 32'h0);
    n = 0;
    while (running !== 1'b0 && n < 64) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 64) give_up();
  endtask : run_to

  task automatic t_regs();
    rc(mie_pkg::ADR_STATUS, 32'h18);
    rc(mie_pkg::ADR_PC, 32'h0);
    wr(mie_pkg::ADR_WORK, 32'hA5);
    rc(mie_pkg::ADR_WORK, 32'hA5);
    wr(mie_pkg::ADR_PC, 32'h1FFF);
    rc(mie_pkg::ADR_PC, 32'h0);
    wr(12'h100, 32'hFF);
    rc(12'h100, 32'h0);
    wr(mie_pkg::ADR_LATCH, 32'hFF);
    rc(mie_pkg::ADR_LATCH, 32'h1F);
    wr(fa(127), 32'h5A);
    rc(fa(127), 32'h5A);
    $display("test regs done");
  endtask : t_regs

  task automatic t_alu();
    do_reset();
    pm.mem[0] = 14'h33F8;
    pm.mem[1] = 14'h3E08;
    pm.mem[2] = 14'h008B;
    pm.mem[3] = fd(14'h0D00, 1'b1, 7'd12);
    pm.mem[4] = 14'h303C;
    pm.mem[5] = fd(14'h0700, 1'b0, 7'd10);
    pm.mem[6] = fd(14'h0500, 1'b1, 7'd13);
    pm.mem[7] = fd(14'h0400, 1'b0, 7'd14);
    pm.mem[8] = 14'h390F;
    pm.mem[9] = 14'h3830;
    pm.mem[10] = 14'h0093;
    pm.mem[11] = fd(14'h0900, 1'b1, 7'd15);
    pm.mem[12] = fd(14'h0A00, 1'b1, 7'd16);
    pm.mem[13] = fd(14'h0300, 1'b1, 7'd17);
    pm.mem[14] = fd(14'h0800, 1'b0, 7'd10);
    pm.mem[15] = 14'h0192;
    pm.mem[16] = bt(14'h1400, 3'd7, 7'd18);
    pm.mem[17] = bt(14'h1000, 3'd0, 7'd12);
    pm.mem[18] = 14'h2812;
    wr(fa(10), 32'h41);
    wr(fa(11), 32'hEE);
    wr(fa(12), 32'h81);
    wr(fa(13), 32'h0F);
    wr(fa(14), 32'h80);
    wr(fa(15), 32'hFF);
    wr(fa(16), 32'h7F);
    wr(fa(17), 32'h01);
    wr(fa(18), 32'h55);
    wr(mie_pkg::ADR_CTRL, 32'h1);
    ce <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk(32'(pc), 32'h0);
    ce <= 1'b1;
    run_to(13'd18);
    rc(fa(11), 32'h00);
    rc(fa(12), 32'h02);
    rc(fa(10), 32'h41);
    rc(fa(13), 32'h0D);
    rc(fa(19), 32'h3D);
    rc(fa(15), 32'h00);
    rc(fa(16), 32'h80);
    rc(fa(17), 32'h00);
    rc(fa(18), 32'h80);
    rc(mie_pkg::ADR_WORK, 32'h41);
    rc(mie_pkg::ADR_STATUS, 32'h1C);
    $display("test alu done");
  endtask : t_alu

  task automatic t_flow();
    do_reset();
    pm.mem[0] = 14'h3822;
    pm.mem[1] = bt(14'h1C00, 3'd2, 7'd22);
    pm.mem[2] = 14'h019A;
    pm.mem[3] = bt(14'h1800, 3'd2, 7'd22);
    pm.mem[4] = bt(14'h1400, 3'd0, 7'd25);
    pm.mem[5] = bt(14'h1800, 3'd0, 7'd22);
    pm.mem[6] = 14'h0198;
    pm.mem[7] = fd(14'h0B00, 1'b1, 7'd20);
    pm.mem[8] = 14'h0197;
    pm.mem[9] = fd(14'h0F00, 1'b0, 7'd21);
    pm.mem[10] = 14'h3055;
    pm.mem[11] = bt(14'h1C00, 3'd1, 7'd22);
    pm.mem[12] = 14'h200F;
    pm.mem[13] = 14'h280D;
    pm.mem[13'h180D] = 14'h280D;
    pm.mem[13'h180F] = 14'h0064;
    pm.mem[13'h1811] = fd(14'h0800, 1'b1, 7'd20);
    pm.mem[13'h1812] = 14'h0009;
    wr(mie_pkg::ADR_LATCH, 32'h1F);
    wr(fa(20), 32'h01);
    wr(fa(21), 32'hFF);
    wr(fa(22), 32'h04);
    wr(fa(23), 32'h77);
    wr(fa(24), 32'h66);
    wr(fa(25), 32'h00);
    wr(fa(26), 32'h5A);
    run_to(13'h180D);
    rc(fa(26), 32'h5A);
    rc(fa(25), 32'h01);
    rc(fa(24), 32'h66);
    rc(fa(20), 32'h00);
    rc(fa(23), 32'h77);
    rc(fa(21), 32'hFF);
    rc(mie_pkg::ADR_WORK, 32'h00);
    rc(mie_pkg::ADR_STATUS, 32'h1C);
    rc(mie_pkg::ADR_IRQ, 32'h1);
    rc(mie_pkg::ADR_PC, 32'h180D);
    bus(1'b0, mie_pkg::ADR_WATCHDOG, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h0);
    chk(32'(rd[15:8] < 8'h10), 32'h1);
    $display("test flow done");
  endtask : t_flow

  initial begin
    do_reset();
    t_regs();
    t_alu();
    t_flow();
    report_and_stop();
  end
endmodule : tb
